//--- pipw_pkg.sv
// Register map, field layout and constants of the picture-in-picture addressing block
package pipw_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address on APB is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_SUB_WINDOW_ENABLE_CTRL = 10'h071;
	localparam logic [9:0] IDX_ORIENT_CTRL = 10'h0A0;
	localparam logic [9:0] IDX_MAIN_START_ADDR_LOW = 10'h074;
	localparam logic [9:0] IDX_MAIN_START_ADDR_MID = 10'h075;
	localparam logic [9:0] IDX_MAIN_START_ADDR_HIGH = 10'h076;
	localparam logic [9:0] IDX_MAIN_LINE_OFFSET_LOW = 10'h078;
	localparam logic [9:0] IDX_MAIN_LINE_OFFSET_HIGH = 10'h079;
	localparam logic [9:0] IDX_OVERLAY_START_ADDR_LOW = 10'h07C;
	localparam logic [9:0] IDX_OVERLAY_START_ADDR_MID = 10'h07D;
	localparam logic [9:0] IDX_OVERLAY_START_ADDR_HIGH = 10'h07E;
	localparam logic [9:0] IDX_OVERLAY_LINE_OFFSET_LOW = 10'h080;
	localparam logic [9:0] IDX_OVERLAY_LINE_OFFSET_HIGH = 10'h081;
	localparam logic [9:0] IDX_OVERLAY_HSTART_LOW = 10'h084;
	localparam logic [9:0] IDX_OVERLAY_HSTART_HIGH = 10'h085;
	localparam logic [9:0] IDX_OVERLAY_VSTART_LOW = 10'h088;
	localparam logic [9:0] IDX_OVERLAY_VSTART_HIGH = 10'h089;
	localparam logic [9:0] IDX_OVERLAY_HEND_LOW = 10'h08C;
	localparam logic [9:0] IDX_OVERLAY_HEND_HIGH = 10'h08D;
	localparam logic [9:0] IDX_OVERLAY_VEND_LOW = 10'h090;
	localparam logic [9:0] IDX_OVERLAY_VEND_HIGH = 10'h091;

	// ----------------------------------------------------------------
	// Storage slots of the register array
	// ----------------------------------------------------------------
	localparam int NUM_SLOTS = 20;
	localparam logic [4:0] SL_CTRL = 5'h00;
	localparam logic [4:0] SL_ORIENT = 5'h01;
	localparam logic [4:0] SL_MSTART = 5'h02;
	localparam logic [4:0] SL_MOFF = 5'h05;
	localparam logic [4:0] SL_SSTART = 5'h07;
	localparam logic [4:0] SL_SOFF = 5'h0A;
	localparam logic [4:0] SL_HSTART = 5'h0C;
	localparam logic [4:0] SL_VSTART = 5'h0E;
	localparam logic [4:0] SL_HEND = 5'h10;
	localparam logic [4:0] SL_VEND = 5'h12;

	// ----------------------------------------------------------------
	// Fields and values
	// ----------------------------------------------------------------
	localparam int OVL_EN_BIT = 4;
	localparam int ROT90_BIT = 0;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] FULL_MASK = 8'hFF;
	localparam logic [7:0] POS_HI_MASK = 8'h03;
	localparam int APB_IDX_LSB = 2;
	localparam int APB_IDX_MSB = 11;
	localparam logic [1:0] BYTE_LANE_PAD = 2'h0;
	localparam logic [23:0] DATA_PAD = 24'h000000;

endpackage

//--- pipw_addr.sv
// Picture-in-picture address generator with APB register bank
module pipw_addr #(
	parameter int POS_W = 10,
	parameter int ADDR_W = 24,
	parameter int OFF_W = 16
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_fetch_valid,
	input wire logic [POS_W-1:0] i_pos_word,
	input wire logic [POS_W-1:0] i_pos_line,
	output logic o_fetch_valid,
	output logic [ADDR_W-1:0] o_word_addr,
	output logic [ADDR_W+1:0] o_byte_addr,
	output logic o_overlay_sel,
	output logic o_rotated
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Maps a register index to {hit, slot}
	function automatic logic [5:0] slot_of(input logic [9:0] idx);
		logic [5:0] r;
		r = 6'h00;
		case (idx)
			pipw_pkg::IDX_SUB_WINDOW_ENABLE_CTRL: r = {1'b1, pipw_pkg::SL_CTRL};
			pipw_pkg::IDX_ORIENT_CTRL: r = {1'b1, pipw_pkg::SL_ORIENT};
			pipw_pkg::IDX_MAIN_START_ADDR_LOW: r = {1'b1, pipw_pkg::SL_MSTART};
			pipw_pkg::IDX_MAIN_START_ADDR_MID: r = {1'b1, 5'(pipw_pkg::SL_MSTART + 5'h01)};
			pipw_pkg::IDX_MAIN_START_ADDR_HIGH: r = {1'b1, 5'(pipw_pkg::SL_MSTART + 5'h02)};
			pipw_pkg::IDX_MAIN_LINE_OFFSET_LOW: r = {1'b1, pipw_pkg::SL_MOFF};
			pipw_pkg::IDX_MAIN_LINE_OFFSET_HIGH: r = {1'b1, 5'(pipw_pkg::SL_MOFF + 5'h01)};
			pipw_pkg::IDX_OVERLAY_START_ADDR_LOW: r = {1'b1, pipw_pkg::SL_SSTART};
			pipw_pkg::IDX_OVERLAY_START_ADDR_MID: r = {1'b1, 5'(pipw_pkg::SL_SSTART + 5'h01)};
			pipw_pkg::IDX_OVERLAY_START_ADDR_HIGH: r = {1'b1, 5'(pipw_pkg::SL_SSTART + 5'h02)};
			pipw_pkg::IDX_OVERLAY_LINE_OFFSET_LOW: r = {1'b1, pipw_pkg::SL_SOFF};
			pipw_pkg::IDX_OVERLAY_LINE_OFFSET_HIGH: r = {1'b1, 5'(pipw_pkg::SL_SOFF + 5'h01)};
			pipw_pkg::IDX_OVERLAY_HSTART_LOW: r = {1'b1, pipw_pkg::SL_HSTART};
			pipw_pkg::IDX_OVERLAY_HSTART_HIGH: r = {1'b1, 5'(pipw_pkg::SL_HSTART + 5'h01)};
			pipw_pkg::IDX_OVERLAY_VSTART_LOW: r = {1'b1, pipw_pkg::SL_VSTART};
			pipw_pkg::IDX_OVERLAY_VSTART_HIGH: r = {1'b1, 5'(pipw_pkg::SL_VSTART + 5'h01)};
			pipw_pkg::IDX_OVERLAY_HEND_LOW: r = {1'b1, pipw_pkg::SL_HEND};
			pipw_pkg::IDX_OVERLAY_HEND_HIGH: r = {1'b1, 5'(pipw_pkg::SL_HEND + 5'h01)};
			pipw_pkg::IDX_OVERLAY_VEND_LOW: r = {1'b1, pipw_pkg::SL_VEND};
			pipw_pkg::IDX_OVERLAY_VEND_HIGH: r = {1'b1, 5'(pipw_pkg::SL_VEND + 5'h01)};
			default: r = 6'h00;
		endcase
		return r;
	endfunction

	// Upper bytes of position values keep only two bits
	function automatic logic [7:0] mask_of(input logic [4:0] slot);
		logic [7:0] m;
		m = pipw_pkg::FULL_MASK;
		case (slot)
			5'(pipw_pkg::SL_HSTART + 5'h01): m = pipw_pkg::POS_HI_MASK;
			5'(pipw_pkg::SL_VSTART + 5'h01): m = pipw_pkg::POS_HI_MASK;
			5'(pipw_pkg::SL_HEND + 5'h01): m = pipw_pkg::POS_HI_MASK;
			5'(pipw_pkg::SL_VEND + 5'h01): m = pipw_pkg::POS_HI_MASK;
			default: m = pipw_pkg::FULL_MASK;
		endcase
		return m;
	endfunction

	function automatic logic in_range(
		input logic [POS_W-1:0] v,
		input logic [POS_W-1:0] lo,
		input logic [POS_W-1:0] hi
	);
		return (v >= lo) && (v <= hi);
	endfunction

	// Word address of a pixel: base plus whole lines, then along the line.
	// Rotated images are stored from the far end of each line backwards.
	function automatic logic [ADDR_W-1:0] addr_of(
		input logic [ADDR_W-1:0] base,
		input logic [POS_W-1:0] line,
		input logic [OFF_W-1:0] off,
		input logic [POS_W-1:0] word,
		input logic rot
	);
		logic [POS_W+OFF_W-1:0] prod;
		logic [ADDR_W-1:0] a;
		prod = line * off;
		a = ADDR_W'(base + ADDR_W'(prod));
		if (rot) begin
			a = ADDR_W'(a - ADDR_W'(word));
		end else begin
			a = ADDR_W'(a + ADDR_W'(word));
		end
		return a;
	endfunction

	// ----------------------------------------------------------------
	// Register bank
	// ----------------------------------------------------------------
	logic [7:0] regs_q [pipw_pkg::NUM_SLOTS];
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	wire [9:0] bus_idx = i_paddr[pipw_pkg::APB_IDX_MSB:pipw_pkg::APB_IDX_LSB];
	wire [5:0] bus_hit = slot_of(bus_idx);
	wire bus_mapped = bus_hit[5] && (i_paddr[1:0] == pipw_pkg::BYTE_LANE_PAD) &&
		(i_paddr[31:12] == 20'h00000);
	wire [4:0] bus_slot = bus_hit[4:0];
	wire bus_setup = i_psel && !i_penable;
	wire bus_commit = i_psel && i_penable && pready_q;
	wire bus_wr = bus_commit && i_pwrite && bus_mapped && i_pstrb[0];
	wire [7:0] bus_rbyte = bus_mapped ? (regs_q[bus_slot] & mask_of(bus_slot)) : pipw_pkg::RESET_VAL;

	// Answer comes in the first access cycle; data captured during setup
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= bus_setup;
			if (bus_setup) begin
				pslverr_q <= !bus_mapped;
				prdata_q <= {pipw_pkg::DATA_PAD, bus_rbyte};
			end else if (bus_commit) begin
				pslverr_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			for (int k = 0; k < pipw_pkg::NUM_SLOTS; k++) begin
				regs_q[k] <= pipw_pkg::RESET_VAL;
			end
		end else if (bus_wr) begin
			regs_q[bus_slot] <= i_pwdata[7:0] & mask_of(bus_slot);
		end
	end

	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;

	// ----------------------------------------------------------------
	// Assembled register values
	// ----------------------------------------------------------------
	wire ovl_en = regs_q[pipw_pkg::SL_CTRL][pipw_pkg::OVL_EN_BIT];
	wire rot90 = regs_q[pipw_pkg::SL_ORIENT][pipw_pkg::ROT90_BIT];
	wire [ADDR_W-1:0] main_start = ADDR_W'({regs_q[pipw_pkg::SL_MSTART + 2],
		regs_q[pipw_pkg::SL_MSTART + 1], regs_q[pipw_pkg::SL_MSTART]});
	wire [ADDR_W-1:0] ovl_start = ADDR_W'({regs_q[pipw_pkg::SL_SSTART + 2],
		regs_q[pipw_pkg::SL_SSTART + 1], regs_q[pipw_pkg::SL_SSTART]});
	wire [OFF_W-1:0] main_off = OFF_W'({regs_q[pipw_pkg::SL_MOFF + 1],
		regs_q[pipw_pkg::SL_MOFF]});
	wire [OFF_W-1:0] ovl_off = OFF_W'({regs_q[pipw_pkg::SL_SOFF + 1],
		regs_q[pipw_pkg::SL_SOFF]});
	wire [POS_W-1:0] hstart = POS_W'({regs_q[pipw_pkg::SL_HSTART + 1][1:0],
		regs_q[pipw_pkg::SL_HSTART]});
	wire [POS_W-1:0] vstart = POS_W'({regs_q[pipw_pkg::SL_VSTART + 1][1:0],
		regs_q[pipw_pkg::SL_VSTART]});
	wire [POS_W-1:0] hend = POS_W'({regs_q[pipw_pkg::SL_HEND + 1][1:0],
		regs_q[pipw_pkg::SL_HEND]});
	wire [POS_W-1:0] vend = POS_W'({regs_q[pipw_pkg::SL_VEND + 1][1:0],
		regs_q[pipw_pkg::SL_VEND]});

	// ----------------------------------------------------------------
	// Overlay hit test
	// ----------------------------------------------------------------
	// End registers hold last position, so the bound is inclusive
	wire hit_unrot = in_range(i_pos_word, hstart, hend) &&
		in_range(i_pos_line, vstart, vend);
	wire hit_rot = in_range(i_pos_line, hstart, hend) &&
		in_range(i_pos_word, vstart, vend);
	wire ovl_hit = ovl_en && (rot90 ? hit_rot : hit_unrot);

	// Position relative to the overlay origin
	wire [POS_W-1:0] rel_line = rot90 ? POS_W'(i_pos_line - hstart) : POS_W'(i_pos_line - vstart);
	wire [POS_W-1:0] rel_word = rot90 ? POS_W'(i_pos_word - vstart) : POS_W'(i_pos_word - hstart);

	wire [ADDR_W-1:0] main_addr = addr_of(main_start, i_pos_line, main_off, i_pos_word, rot90);
	wire [ADDR_W-1:0] ovl_addr = addr_of(ovl_start, rel_line, ovl_off, rel_word, rot90);
	wire [ADDR_W-1:0] sel_addr = ovl_hit ? ovl_addr : main_addr;

	// ----------------------------------------------------------------
	// Fetch output stage
	// ----------------------------------------------------------------
	logic fetch_valid_q;
	logic [ADDR_W-1:0] word_addr_q;
	logic overlay_sel_q;
	logic rotated_q;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			fetch_valid_q <= 1'b0;
			word_addr_q <= '0;
			overlay_sel_q <= 1'b0;
			rotated_q <= 1'b0;
		end else begin
			fetch_valid_q <= i_fetch_valid;
			rotated_q <= rot90;
			if (i_fetch_valid) begin
				word_addr_q <= sel_addr;
				overlay_sel_q <= ovl_hit;
			end
		end
	end

	assign o_fetch_valid = fetch_valid_q;
	assign o_word_addr = word_addr_q;
	assign o_byte_addr = {word_addr_q, pipw_pkg::BYTE_LANE_PAD};
	assign o_overlay_sel = overlay_sel_q;
	assign o_rotated = rotated_q;

endmodule

//--- pipw_addr_chk.sv
// Concurrent checks on the ports of the picture-in-picture addressing block
module pipw_addr_chk #(
	parameter int ADDR_W = 24
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_fetch_valid,
	input wire logic o_fetch_valid,
	input wire logic [ADDR_W-1:0] o_word_addr,
	input wire logic [ADDR_W+1:0] o_byte_addr,
	input wire logic o_overlay_sel,
	input wire logic o_rotated
);
	// ----
	// Shadow of enable and orientation bits
	// ----
	logic en_q;
	logic rot_q;
	wire commit = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0];
	wire ctrl_hit = i_paddr == {20'h00000, pipw_pkg::IDX_SUB_WINDOW_ENABLE_CTRL, 2'h0};
	wire rot_hit = i_paddr == {20'h00000, pipw_pkg::IDX_ORIENT_CTRL, 2'h0};
	wire hi_hit = i_paddr == {20'h00000, pipw_pkg::IDX_OVERLAY_HSTART_HIGH, 2'h0};
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			en_q <= 1'b0;
			rot_q <= 1'b0;
		end else if (commit && ctrl_hit) begin
			en_q <= i_pwdata[4];
		end else if (commit && rot_hit) begin
			rot_q <= i_pwdata[0];
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_answer;
		i_psel && i_penable && o_pready;
	endsequence
	// ----
	// Assertions
	// ----
	AST_PREADY: assert property (s_setup |=> s_answer)
		else $error("ready missing in first access cycle");
	AST_ERR: assert property (s_setup and i_paddr[1:0] != 2'h0 |=> o_pslverr)
		else $error("misaligned access not refused");
	AST_POS_HI: assert property (s_setup and hi_hit && !i_pwrite |=> o_prdata[31:2] == 30'h0)
		else $error("upper position byte shows unused bits");
	AST_FETCH: assert property (i_fetch_valid |=> o_fetch_valid)
		else $error("fetch answer not one cycle later");
	AST_HOLD: assert property (!i_fetch_valid |=> $stable(o_word_addr) && $stable(o_overlay_sel))
		else $error("fetch result changed without request");
	AST_BYTE: assert property (o_byte_addr == {o_word_addr, 2'h0})
		else $error("byte address is not four times word address");
	AST_EN_OFF: assert property (i_fetch_valid && !en_q |=> !o_overlay_sel)
		else $error("overlay selected while disabled");
	AST_ROT: assert property (o_rotated == $past(rot_q))
		else $error("rotation flag does not follow register");
endmodule

bind pipw_addr pipw_addr_chk #(.ADDR_W(ADDR_W)) chk (.i_clk(i_clk), .i_reset(i_reset),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .i_fetch_valid(i_fetch_valid), .o_fetch_valid(o_fetch_valid),
	.o_word_addr(o_word_addr), .o_byte_addr(o_byte_addr), .o_overlay_sel(o_overlay_sel),
	.o_rotated(o_rotated));

//--- pip_subwindow_addressing_tb.sv
// Self-checking bench for the picture-in-picture addressing block
module pip_subwindow_addressing_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk, i_reset, i_psel, i_penable, i_pwrite, i_fetch_valid, rerr;
	logic [31:0] i_paddr, i_pwdata, o_prdata, rdat;
	logic [3:0] i_pstrb;
	logic [9:0] i_pos_word, i_pos_line;
	logic o_pready, o_pslverr, o_fetch_valid, o_overlay_sel, o_rotated;
	logic [23:0] o_word_addr;
	logic [25:0] o_byte_addr;
	int mismatches, n_tests;
	localparam logic [9:0] IX [9] = '{pipw_pkg::IDX_MAIN_START_ADDR_LOW,
		pipw_pkg::IDX_MAIN_LINE_OFFSET_LOW, pipw_pkg::IDX_OVERLAY_START_ADDR_LOW,
		pipw_pkg::IDX_OVERLAY_LINE_OFFSET_LOW, pipw_pkg::IDX_OVERLAY_HSTART_LOW,
		pipw_pkg::IDX_OVERLAY_VSTART_LOW, pipw_pkg::IDX_OVERLAY_HEND_LOW,
		pipw_pkg::IDX_OVERLAY_VEND_LOW, pipw_pkg::IDX_ORIENT_CTRL};
	localparam int NB [9] = '{3, 2, 3, 2, 2, 2, 2, 2, 1};
	localparam logic [23:0] P5 [9] = '{24'h000000, 24'h000028, 24'h002580, 24'h000014,
		24'h00000A, 24'h00003C, 24'h00001D, 24'h0000B3, 24'h000000};
	localparam logic [23:0] P6 [9] = '{24'h00001D, 24'h00001E, 24'h00258E, 24'h00000F,
		24'h000050, 24'h000007, 24'h0000EF, 24'h000015, 24'h000001};
	localparam logic [9:0] CT = pipw_pkg::IDX_SUB_WINDOW_ENABLE_CTRL;

	pipw_addr uut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_fetch_valid(i_fetch_valid), .i_pos_word(i_pos_word), .i_pos_line(i_pos_line),
		.o_fetch_valid(o_fetch_valid), .o_word_addr(o_word_addr), .o_byte_addr(o_byte_addr),
		.o_overlay_sel(o_overlay_sel), .o_rotated(o_rotated));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// ----
	// Tasks
	// ----
	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= {24'h000000, d};
		@(posedge i_clk);
		i_penable <= 1'b1;
		// Each pass waits one rising edge and looks at ready as sampled there
		@(posedge i_clk);
		while (o_pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				mismatches++;
				complete_run();
			end
			@(posedge i_clk);
		end
		rdat = o_prdata;
		rerr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task wv(input logic [9:0] idx, input logic [23:0] v, input int nb);
		for (int i = 0; i < nb; i++) apb(1'b1, {20'h00000, idx + 10'(i), 2'h0}, v[8*i +: 8]);
	endtask
	task rv(input logic [9:0] idx, input logic [23:0] exp, input int nb);
		logic [23:0] got;
		got = 24'h000000;
		for (int i = 0; i < nb; i++) begin
			apb(1'b0, {20'h00000, idx + 10'(i), 2'h0}, 8'h00);
			got[8*i +: 8] = rdat[7:0];
		end
		chk({8'h00, got}, {8'h00, exp});
	endtask
	task prog(input logic [23:0] v [9]);
		for (int k = 0; k < 9; k++) wv(IX[k], v[k], NB[k]);
		for (int k = 0; k < 9; k++) rv(IX[k], v[k], NB[k]);
	endtask
	task ft(input logic [9:0] w, input logic [9:0] l, input logic sel, input logic [23:0] a);
		@(posedge i_clk);
		i_fetch_valid <= 1'b1;
		i_pos_word <= w;
		i_pos_line <= l;
		@(posedge i_clk);
		i_fetch_valid <= 1'b0;
		@(negedge i_clk);
		chk({31'h0, o_fetch_valid}, 32'h1);
		chk({31'h0, o_overlay_sel}, {31'h0, sel});
		chk({8'h00, o_word_addr}, {8'h00, a});
		chk({6'h00, o_byte_addr}, {6'h00, a, 2'h0});
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		mismatches = 0;
		n_tests = 0;
		i_reset = 1'b1;
		{i_psel, i_penable, i_pwrite, i_fetch_valid} = 4'h0;
		{i_paddr, i_pwdata} = 64'h0;
		i_pstrb = 4'hF;
		{i_pos_word, i_pos_line} = 20'h00000;
		repeat (8) @(posedge i_clk);
		i_reset <= 1'b0;
		rv(IX[2], 24'h000000, 3);
		wv(pipw_pkg::IDX_OVERLAY_HSTART_HIGH, 24'h0000FF, 1);
		rv(pipw_pkg::IDX_OVERLAY_HSTART_HIGH, 24'h000003, 1);
		apb(1'b0, 32'h00000004, 8'h00);
		chk({31'h0, rerr}, 32'h1);
		chk(rdat, 32'h0);
		apb(1'b0, 32'h000001C5, 8'h00);
		chk({31'h0, rerr}, 32'h1);
		$display("test registers done");
		prog(P5);
		wv(CT, 24'h000010, 1);
		ft(10'd10, 10'd60, 1'b1, 24'h002580);
		ft(10'd29, 10'd179, 1'b1, 24'h002EDF);
		ft(10'd30, 10'd179, 1'b0, 24'h001C16);
		ft(10'd9, 10'd60, 1'b0, 24'h000969);
		ft(10'd10, 10'd180, 1'b0, 24'h001C2A);
		wv(IX[3], 24'h000028, 2);
		ft(10'd29, 10'd179, 1'b1, 24'h00382B);
		wv(CT, 24'h000000, 1);
		ft(10'd10, 10'd60, 1'b0, 24'h00096A);
		$display("test unrotated done");
		prog(P6);
		wv(CT, 24'h000010, 1);
		ft(10'd7, 10'd80, 1'b1, 24'h00258E);
		chk({31'h0, o_rotated}, 32'h1);
		ft(10'd21, 10'd239, 1'b1, 24'h002ED1);
		ft(10'd22, 10'd239, 1'b0, 24'h001C09);
		ft(10'd6, 10'd80, 1'b0, 24'h000977);
		ft(10'd7, 10'd79, 1'b0, 24'h000958);
		$display("test rotated done");
		complete_run();
	end
endmodule
